//--- rpsq_defines.vh
`ifndef RPSQ_DEFINES_VH
`define RPSQ_DEFINES_VH

// Register offsets
`define RPSQ_OFF_RAIL_ENABLE 8'h16
`define RPSQ_OFF_LOCKOUT 8'h18
`define RPSQ_OFF_STROBE_A 8'h19
`define RPSQ_OFF_STROBE_B 8'h1a

// Reset values
`define RPSQ_RST_RAIL_ENABLE 7'h00
`define RPSQ_RST_LOCKOUT 2'h3
`define RPSQ_RST_STROBE_A 8'h55
`define RPSQ_RST_STROBE_B 8'h5f

// Rail enable bit positions
`define RPSQ_BIT_SWITCH_ONE 6
`define RPSQ_BIT_SWITCH_TWO 5
`define RPSQ_BIT_BUCK_ONE 4
`define RPSQ_BIT_BUCK_TWO 3
`define RPSQ_BIT_BUCK_THREE 2
`define RPSQ_BIT_REG_ONE 1
`define RPSQ_BIT_REG_TWO 0

// Strobe codes
`define RPSQ_CODE_NONE 4'h0
`define RPSQ_STROBE_FIRST 4'h1
`define RPSQ_STROBE_LAST_LOW 4'h7
`define RPSQ_STROBE_LATE 4'he
`define RPSQ_STROBE_SYS 4'hf

// Lockout thresholds in millivolts
`define RPSQ_LOCKOUT_MV_00 12'd2730
`define RPSQ_LOCKOUT_MV_01 12'd2890
`define RPSQ_LOCKOUT_MV_10 12'd3180
`define RPSQ_LOCKOUT_MV_11 12'd3300

// Sequencer timing
`define RPSQ_CLK_MHZ 25
`define RPSQ_GAP_NS 1000

// Sequencer states
`define RPSQ_ST_IDLE 1'b0
`define RPSQ_ST_RUN 1'b1

`endif

//--- rpsq_strobe_match.v
`timescale 1ns/1ps
`default_nettype none
`include "rpsq_defines.vh"

module rpsq_strobe_match #(
   parameter CODE_W = 4
) (
   // Assignment
   input wire [CODE_W-1:0] code,
   // Sequencer
   input wire strobeFire,
   input wire [CODE_W-1:0] strobeNum,
   input wire systemSupply,
   // Result
   output wire hit
);
   // [RULE10] Zero code never matches
   wire assigned = (code != `RPSQ_CODE_NONE);
   // [RULE11] Match stepped strobe
   wire stepHit = strobeFire && assigned && (code == strobeNum);
   // [RULE15] Strobe fifteen follows supply
   wire sysHit = systemSupply && (code == `RPSQ_STROBE_SYS);
   assign hit = stepHit || sysHit;
endmodule

`default_nettype wire

//--- rpsq_rail_seq.v
// What this block does
// [RULE1] Rail enable register at 0x16, reset zero, bit7 unused, seven rail bits.
// [RULE2] Switch one output only on while power-enable pin high.
// [RULE3] Switch two output only on while power-enable pin high.
// [RULE4] All three bucks only on while power-enable pin high.
// [RULE5] Buck enable bit zero disables, one enables.
// [RULE6] Switch two configuration bit: zero off, one on.
// [RULE7] Lockout register at 0x18, two-bit field resets to binary 11.
// [RULE8] Lockout codes select 2.73, 2.89, 3.18, 3.30 volts.
// [RULE9] Register 0x19 holds buck one and two strobes, top bits read-only.
// [RULE10] Strobe code zero leaves rail out of sequencing.
// [RULE11] Codes one to seven enable rail at that strobe.
// [RULE12] Register 0x1a holds buck three (top read-only) and regulator one.
// [RULE13] Regulator one codes eight and nine also exclude rail.
// [RULE14] Regulator one code 1110 enables at strobe fourteen.
// [RULE15] Regulator one code 1111 enables at strobe fifteen, with system supply.
// [RULE16] Strobes rise in order; matching rails enabled; spacing is parameter.
// [RULE17] Host unlocks password before writing protected registers.
`timescale 1ns/1ps
`default_nettype none
`include "rpsq_defines.vh"

module rpsq_rail_seq #(
   parameter STROBE_A_RESET = `RPSQ_RST_STROBE_A,
   parameter STROBE_B_RESET = `RPSQ_RST_STROBE_B,
   parameter GAP_CYCLES = (`RPSQ_GAP_NS * `RPSQ_CLK_MHZ + 999) / 1000
) (
   // Clock and reset
   input wire mclk,
   input wire arst_n,
   // Register port from the serial interface
   input wire [7:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrite,
   input wire regRead,
   input wire writeUnlocked,
   output reg [7:0] regRdData,
   output reg regRdValid,
   // Pins and supply status
   input wire power_enable_pin,
   input wire systemSupply,
   // Sequencer control
   input wire seqStart,
   input wire seqAbort,
   output reg seqBusy,
   output reg seqStrobe,
   output reg [3:0] seqStep,
   // Rail drives
   output reg switch_one,
   output reg switch_two,
   output reg buck_one,
   output reg buck_two,
   output reg buck_three,
   output reg regulator_one,
   output reg regulator_two,
   // Lockout
   output reg [1:0] lockout_level,
   output reg [11:0] lockoutMillivolts
);
   reg [6:0] railEnable;
   reg [2:0] buck_one_strobe_w;
   reg [2:0] buck_two_strobe_w;
   reg [2:0] buck_three_strobe_w;
   reg [3:0] regulator_one_strobe;
   reg state;
   reg [15:0] gapCount;
   reg [3:0] nextStrobe;
   reg [6:0] next_railEnable;
   reg [11:0] next_mv;

   wire [3:0] buck_one_strobe = {1'b0, buck_one_strobe_w};
   wire [3:0] buck_two_strobe = {1'b0, buck_two_strobe_w};
   wire [3:0] buck_three_strobe = {1'b0, buck_three_strobe_w};
   wire [7:0] strobeAssignA = {buck_one_strobe, buck_two_strobe};
   wire [7:0] strobeAssignB = {buck_three_strobe, regulator_one_strobe};

   // Protected writes only land once unlocked
   // [RULE17] Gate on unlock
   wire wrOk = regWrite && writeUnlocked;
   wire wrEnable = wrOk && (regAddr == `RPSQ_OFF_RAIL_ENABLE);
   wire wrLockout = wrOk && (regAddr == `RPSQ_OFF_LOCKOUT);
   wire wrStrobeA = wrOk && (regAddr == `RPSQ_OFF_STROBE_A);
   wire wrStrobeB = wrOk && (regAddr == `RPSQ_OFF_STROBE_B);

   wire hitBuckOne;
   wire hitBuckTwo;
   wire hitBuckThree;
   wire hitRegOne;

   rpsq_strobe_match #(.CODE_W(4)) uMatchBuckOne (
      .code(buck_one_strobe),
      .strobeFire(seqStrobe),
      .strobeNum(seqStep),
      .systemSupply(systemSupply),
      .hit(hitBuckOne)
   );
   rpsq_strobe_match #(.CODE_W(4)) uMatchBuckTwo (
      .code(buck_two_strobe),
      .strobeFire(seqStrobe),
      .strobeNum(seqStep),
      .systemSupply(systemSupply),
      .hit(hitBuckTwo)
   );
   rpsq_strobe_match #(.CODE_W(4)) uMatchBuckThree (
      .code(buck_three_strobe),
      .strobeFire(seqStrobe),
      .strobeNum(seqStep),
      .systemSupply(systemSupply),
      .hit(hitBuckThree)
   );
   // [RULE13] Codes eight, nine never stepped
   rpsq_strobe_match #(.CODE_W(4)) uMatchRegOne (
      .code(regulator_one_strobe),
      .strobeFire(seqStrobe),
      .strobeNum(seqStep),
      .systemSupply(systemSupply),
      .hit(hitRegOne)
   );

   // Strobe hits set enable bits; a set beats a same-cycle software clear
   always @* begin
      next_railEnable = railEnable;
      if (wrEnable) begin
         next_railEnable = regWrData[6:0];
      end
      // [RULE16] Enable matching rails
      if (hitBuckOne) begin
         next_railEnable[`RPSQ_BIT_BUCK_ONE] = 1'b1;
      end
      if (hitBuckTwo) begin
         next_railEnable[`RPSQ_BIT_BUCK_TWO] = 1'b1;
      end
      if (hitBuckThree) begin
         next_railEnable[`RPSQ_BIT_BUCK_THREE] = 1'b1;
      end
      if (hitRegOne) begin
         next_railEnable[`RPSQ_BIT_REG_ONE] = 1'b1;
      end
   end

   // [RULE1] Enable register, bit seven dropped
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         railEnable <= `RPSQ_RST_RAIL_ENABLE;
      end else begin
         railEnable <= next_railEnable;
      end
   end

   // [RULE7] Lockout field store
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lockout_level <= `RPSQ_RST_LOCKOUT;
      end else if (wrLockout) begin
         lockout_level <= regWrData[1:0];
      end
   end

   // [RULE8] Threshold decode
   always @* begin
      case (lockout_level)
         2'h0: next_mv = `RPSQ_LOCKOUT_MV_00;
         2'h1: next_mv = `RPSQ_LOCKOUT_MV_01;
         2'h2: next_mv = `RPSQ_LOCKOUT_MV_10;
         default: next_mv = `RPSQ_LOCKOUT_MV_11;
      endcase
   end

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lockoutMillivolts <= `RPSQ_LOCKOUT_MV_11;
      end else begin
         lockoutMillivolts <= next_mv;
      end
   end

   // Read-only top bits are simply not stored, so they always read zero
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         buck_one_strobe_w <= STROBE_A_RESET[6:4];
         buck_two_strobe_w <= STROBE_A_RESET[2:0];
         buck_three_strobe_w <= STROBE_B_RESET[6:4];
         regulator_one_strobe <= STROBE_B_RESET[3:0];
      end else begin
         // [RULE9] Writable low bits only
         if (wrStrobeA) begin
            buck_one_strobe_w <= regWrData[6:4];
            buck_two_strobe_w <= regWrData[2:0];
         end
         // [RULE12] Buck three masked, regulator full
         if (wrStrobeB) begin
            buck_three_strobe_w <= regWrData[6:4];
            regulator_one_strobe <= regWrData[3:0];
         end
      end
   end

   // Register read, unmapped offsets answer zero
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         regRdData <= 8'h00;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRead;
         if (!regRead) begin
            regRdData <= regRdData;
         end else if (regAddr == `RPSQ_OFF_RAIL_ENABLE) begin
            regRdData <= {1'b0, railEnable};
         end else if (regAddr == `RPSQ_OFF_LOCKOUT) begin
            regRdData <= {6'h00, lockout_level};
         end else if (regAddr == `RPSQ_OFF_STROBE_A) begin
            regRdData <= strobeAssignA;
         end else if (regAddr == `RPSQ_OFF_STROBE_B) begin
            regRdData <= strobeAssignB;
         end else begin
            regRdData <= 8'h00;
         end
      end
   end

   // Sequencer: steps 1..7 then 14; 15 is tied to the supply level
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state <= `RPSQ_ST_IDLE;
         gapCount <= 16'h0000;
         nextStrobe <= `RPSQ_STROBE_FIRST;
         seqStrobe <= 1'b0;
         seqStep <= `RPSQ_CODE_NONE;
         seqBusy <= 1'b0;
      end else begin
         seqStrobe <= 1'b0;
         case (state)
            `RPSQ_ST_IDLE: begin
               seqBusy <= 1'b0;
               if (seqStart) begin
                  state <= `RPSQ_ST_RUN;
                  seqBusy <= 1'b1;
                  gapCount <= 16'h0000;
                  nextStrobe <= `RPSQ_STROBE_FIRST;
               end
            end
            default: begin
               if (seqAbort) begin
                  state <= `RPSQ_ST_IDLE;
                  seqBusy <= 1'b0;
               end else if (gapCount == GAP_CYCLES[15:0] - 16'h0001) begin
                  // [RULE16] Ascending strobe issue
                  gapCount <= 16'h0000;
                  seqStrobe <= 1'b1;
                  seqStep <= nextStrobe;
                  if (nextStrobe == `RPSQ_STROBE_LAST_LOW) begin
                     // [RULE14] Late strobe fourteen
                     nextStrobe <= `RPSQ_STROBE_LATE;
                  end else if (nextStrobe == `RPSQ_STROBE_LATE) begin
                     state <= `RPSQ_ST_IDLE;
                     seqBusy <= 1'b0;
                  end else begin
                     nextStrobe <= nextStrobe + 4'h1;
                  end
               end else begin
                  gapCount <= gapCount + 16'h0001;
               end
            end
         endcase
      end
   end

   // Rail drives, registered so outputs are glitch-free
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         switch_one <= 1'b0;
         switch_two <= 1'b0;
         buck_one <= 1'b0;
         buck_two <= 1'b0;
         buck_three <= 1'b0;
         regulator_one <= 1'b0;
         regulator_two <= 1'b0;
      end else begin
         // [RULE2] Switch one needs pin
         switch_one <= railEnable[`RPSQ_BIT_SWITCH_ONE] && power_enable_pin;
         // [RULE3] Switch two needs pin
         // [RULE6] Config bit steers switch two
         switch_two <= railEnable[`RPSQ_BIT_SWITCH_TWO] && power_enable_pin;
         // [RULE4] Bucks need pin
         // [RULE5] Bit one enables buck
         buck_one <= railEnable[`RPSQ_BIT_BUCK_ONE] && power_enable_pin;
         buck_two <= railEnable[`RPSQ_BIT_BUCK_TWO] && power_enable_pin;
         buck_three <= railEnable[`RPSQ_BIT_BUCK_THREE] && power_enable_pin;
         regulator_one <= railEnable[`RPSQ_BIT_REG_ONE];
         regulator_two <= railEnable[`RPSQ_BIT_REG_TWO];
      end
   end

endmodule

`default_nettype wire

//--- rpsq_rail_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rpsq_rail_seq_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   // Pin and sequencer
   input wire logic power_enable_pin,
   input wire logic seqBusy,
   input wire logic seqStrobe,
   // Rails and lockout
   input wire logic switch_one,
   input wire logic switch_two,
   input wire logic buck_one,
   input wire logic buck_two,
   input wire logic buck_three,
   input wire logic [1:0] lockout_level,
   input wire logic [11:0] lockoutMillivolts
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   a_enable_top_zero: assert property (regRdValid && $past(regAddr) == 8'h16 |-> !regRdData[7])
      else $error("enable bit 7 reads set");
   a_switch_one_gate: assert property (switch_one |-> $past(power_enable_pin))
      else $error("switch one on with pin low");
   a_switch_two_gate: assert property (switch_two |-> $past(power_enable_pin))
      else $error("switch two on with pin low");
   a_buck_pin_gate: assert property ((buck_one || buck_two || buck_three) |-> $past(power_enable_pin))
      else $error("buck on with pin low");
   a_lockout_bits_zero: assert property (regRdValid && $past(regAddr) == 8'h18 |-> regRdData[7:2] == 6'h00)
      else $error("lockout unused bits set");
   a_lockout_decode: assert property ($stable(lockout_level) |-> lockoutMillivolts ==
      (lockout_level == 2'h0 ? 12'haaa : lockout_level == 2'h1 ? 12'hb4a : lockout_level == 2'h2 ? 12'hc6c : 12'hce4))
      else $error("lockout millivolts wrong");
   a_strobe_ro_bits: assert property (regRdValid && $past(regAddr) == 8'h19 |-> !regRdData[7] && !regRdData[3])
      else $error("read-only strobe bits set");
   a_buck3_ro_bit: assert property (regRdValid && $past(regAddr) == 8'h1a |-> !regRdData[7])
      else $error("buck three top bit set");
   a_strobe_one_cycle: assert property (seqStrobe |-> $past(seqBusy) ##1 !seqStrobe)
      else $error("strobe not a busy single pulse");
endmodule
bind rpsq_rail_seq rpsq_rail_seq_chk rpsq_rail_seq_chk_i (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr),
   .regRdData(regRdData), .regRdValid(regRdValid), .power_enable_pin(power_enable_pin), .seqBusy(seqBusy),
   .seqStrobe(seqStrobe), .switch_one(switch_one), .switch_two(switch_two), .buck_one(buck_one),
   .buck_two(buck_two), .buck_three(buck_three), .lockout_level(lockout_level),
   .lockoutMillivolts(lockoutMillivolts));
`default_nettype wire

//--- rpsq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rpsq_host_model (
   // Clock
   input wire logic mclk,
   // Register port
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   output logic regWrite,
   output logic regRead,
   output logic writeUnlocked,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid
);
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      writeUnlocked = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      writeUnlocked <= u;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
      writeUnlocked <= 1'b0;
      // Idle bus inverted so stale values never pass
      regAddr <= ~a;
      regWrData <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      regAddr <= ~a;
      #1;
      d = (regRdValid === 1'b1) ? regRdData : 8'hxx;
   endtask
endmodule
`default_nettype wire

//--- rpsq_rail_seq_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rpsq_rail_seq_tb;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic power_enable_pin = 1'b0;
   logic systemSupply = 1'b0;
   logic seqStart = 1'b0;
   logic [7:0] regAddr, regWrData, regRdData, rd, a, d, e;
   logic regWrite, regRead, writeUnlocked, regRdValid, seqBusy, seqStrobe, u;
   logic [3:0] seqStep;
   logic [6:0] rails;
   logic [1:0] lockout_level;
   logic [11:0] lockoutMillivolts;
   logic [3:0] c [4];
   logic [7:0] sh [6] = '{8'h00, 8'h00, 8'h03, 8'h55, 8'h5f, 8'h00};
   logic [11:0] mv [4] = '{12'haaa, 12'hb4a, 12'hc6c, 12'hce4};
   logic [3:0] rt [6] = '{4'h0, 4'h8, 4'h9, 4'he, 4'hf, 4'h3};
   int errors = 0;
   int checked = 0;
   int n;
   always #20 mclk = ~mclk;
   rpsq_host_model rpsq_host_model_i (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .writeUnlocked(writeUnlocked), .regRdData(regRdData),
      .regRdValid(regRdValid));
   rpsq_rail_seq #(.GAP_CYCLES(2)) rpsq_rail_seq_i (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .writeUnlocked(writeUnlocked),
      .regRdData(regRdData), .regRdValid(regRdValid), .power_enable_pin(power_enable_pin),
      .systemSupply(systemSupply), .seqStart(seqStart), .seqAbort(1'b0), .seqBusy(seqBusy),
      .seqStrobe(seqStrobe), .seqStep(seqStep), .switch_one(rails[6]), .switch_two(rails[5]),
      .buck_one(rails[4]), .buck_two(rails[3]), .buck_three(rails[2]), .regulator_one(rails[1]),
      .regulator_two(rails[0]), .lockout_level(lockout_level), .lockoutMillivolts(lockoutMillivolts));
   function automatic logic [7:0] rmask(input logic [7:0] x);
      case (x)
         8'h16: return 8'h7f;
         8'h18: return 8'h03;
         8'h19: return 8'h77;
         8'h1a: return 8'h7f;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic hit(input logic [3:0] k, input logic s);
      return (k >= 4'h1 && k <= 4'h7) || k == 4'he || (k == 4'hf && s);
   endfunction
   task automatic cmp_reg(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t value %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_rail(input logic [6:0] got, input logic [6:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t rails %b exp %b", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      void'($urandom(72));
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         a = 8'h16 + 8'($urandom_range(0, 5));
         d = 8'($urandom);
         u = (i < 6) ? 1'b0 : 1'($urandom);
         if (u) sh[a - 8'h16] = d & rmask(a);
         if (i >= 6) rpsq_host_model_i.wr(a, d, u);
         rpsq_host_model_i.rd(a, rd);
         cmp_reg({4'h0, rd}, {4'h0, sh[a - 8'h16]}); // readback
      end
      for (int i = 0; i < 16; i++) begin
         d = (i < 4) ? {8{i[1]}} : 8'($urandom);
         rpsq_host_model_i.wr(8'h16, d, 1'b1);
         power_enable_pin <= i[0];
         repeat (2) @(posedge mclk);
         #1;
         cmp_rail(rails, d[6:0] & {{5{i[0]}}, 2'b11}); // gating
      end
      for (int i = 0; i < 4; i++) begin
         rpsq_host_model_i.wr(8'h18, 8'(i), 1'b1);
         repeat (2) @(posedge mclk);
         #1;
         cmp_reg(mv[i], lockoutMillivolts); // threshold
      end
      for (int r = 0; r < 6; r++) begin
         for (int j = 0; j < 3; j++) c[j] = 4'($urandom_range(0, 7));
         c[3] = rt[r];
         rpsq_host_model_i.wr(8'h19, {c[0], c[1]}, 1'b1);
         rpsq_host_model_i.wr(8'h1a, {c[2], c[3]}, 1'b1);
         systemSupply <= (r == 4);
         rpsq_host_model_i.wr(8'h16, 8'h00, 1'b1);
         seqStart <= 1'b1;
         @(posedge mclk);
         seqStart <= 1'b0;
         n = 0;
         for (int k = 0; k < 60 && n < 8; k++) begin
            @(posedge mclk);
            #1;
            if (seqStrobe === 1'b1) begin
               cmp_reg({8'h00, seqStep}, n < 7 ? 12'(n + 1) : 12'h00e); // strobe order
               n++;
            end
         end
         if (n < 8) begin
            errors++;
            print_verdict;
         end
         repeat (3) @(posedge mclk);
         e = {3'h0, hit(c[0], 1'b0), hit(c[1], 1'b0), hit(c[2], 1'b0), hit(c[3], r == 4), 1'b0};
         rpsq_host_model_i.rd(8'h16, rd);
         cmp_reg({4'h0, rd}, {4'h0, e}); // codes
         cmp_rail(rails, e[6:0]); // rail drive
         systemSupply <= 1'b0;
      end
      print_verdict;
   end
endmodule
`default_nettype wire
